// file: src/float_int_convert_sequencer.sv
/*
  Master and arithmetic sequencers for integer/float conversion, negation
  and channel loading of the float accumulator.
  Assumes the command decoder, address unit and memory channel run on
  ref_clk; their handshakes are taken as same-domain logic.
*/
// Overview of operation
// [RULE1] Integer-to-float issues one memory read with the unscaled index.
// [RULE2] The read integer goes into the prefetch buffer middle word.
// [RULE3] When arithmetic is idle, copy integer to operand middle and high words; code copies it to bits 16 to 31 and 0 to 15.
// [RULE4] After launching integer-to-float, master moves on without waiting.
// [RULE5] Arithmetic sets exponent to 17 hex and moves operand into mantissa.
// [RULE6] Mantissa bits outside 16 to 31 are filled with the sign.
// [RULE7] Then the shared normalize routine finishes integer-to-float.
// [RULE8] Float-to-integer waits for prior arithmetic, then launches conversion.
// [RULE9] Address fetch runs concurrently with the float-to-integer arithmetic.
// [RULE10] Exponent above 15 means too large for a 16 bit integer.
// [RULE11] Overflow loads middle word with largest positive or 8000 hex.
// [RULE12] In range, shift count becomes 23 minus exponent.
// [RULE13] Shift count of 23 or more forces positive zero.
// [RULE14] Otherwise mantissa shifts right by the count, then arithmetic halts.
// [RULE15] Afterwards one memory write, unscaled index, mantissa bits 16 to 31.
// [RULE16] Negation waits, launches negate, and continues at once.
// [RULE17] Negation first ones-complements the mantissa.
// [RULE18] Negation passes both fields through, clearing negative zeros, halts.
// [RULE19] Channel load puts the word into operand register, starts master.
// [RULE20] Start address bits 7 and 6 select the accumulator section.
// [RULE21] Word copied into the section; low-bits load also fills guard.
// [RULE22] Every load re-extends sign into guard, clears negative zeros.
// [RULE23] Arithmetic shows busy while running; master waits end on its drop.
`timescale 1ns/1ns
`include "fic_consts.svh"
module float_int_convert_sequencer (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic cmd_valid, // Command code offered
  input wire fic_pkg::cmd_t cmd_code, // Command to run
  output logic cmd_ready_q, // Master ready for a command
  input wire logic [15:0] index_reg, // Raw index value
  input wire fic_pkg::load_cmd_t load_cmd, // Channel load-accumulator command
  output logic addr_req_q, // Operand address fetch request
  input wire logic addr_done, // Address fetch finished pulse
  output fic_pkg::mem_req_t mem_q, // Memory cycle request
  input wire logic mem_done, // Memory cycle finished pulse
  input wire logic [15:0] mem_rdata, // Memory read data
  output logic arith_busy_q, // Arithmetic sequencer running
  output logic [7:0] exp_q, // Accumulator exponent
  output logic [0:47] mant_q, // Accumulator mantissa, bit 0 is sign
  output logic [3:0] guard_q // Guard digits
);
  import fic_pkg::*;
  typedef enum logic [3:0] {
    M_IDLE, M_I2F_ADDR, M_I2F_RD, M_I2F_WAIT,
    M_F2I_WAIT, M_F2I_ADDR, M_F2I_DONE, M_F2I_WR,
    M_NEG_WAIT, M_LOAD
  } mstate_t;
  typedef enum logic [3:0] {
    A_IDLE, A_I2F_MOVE, A_I2F_FILL, A_NORM,
    A_F2I_CMP, A_F2I_SC, A_F2I_SHIFT, A_ZERO,
    A_NEG_CMPL, A_CLEAN, A_LD_COPY, A_LD_EXT
  } astate_t;
  typedef enum logic [1:0] {
    OP_I2F, OP_F2I, OP_NEG, OP_LOAD
  } aop_t;
  mstate_t m_q;
  astate_t a_q;
  logic [15:0] prefetch_mid_q;
  logic [0:47] operand_input_q;
  logic [1:0] load_sec_q;
  logic start_q;
  aop_t start_op_q;
  logic [8:0] shift_cnt_q;
  logic [5:0] norm_cnt_q;
  logic f2i_done_q;
  logic [8:0] sc_d;
  assign sc_d = `FIC_SC_BASE - {exp_q[7], exp_q};

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      m_q <= M_IDLE;
      cmd_ready_q <= 1'b0;
      addr_req_q <= 1'b0;
      mem_q <= '0;
      start_q <= 1'b0;
      start_op_q <= OP_I2F;
      prefetch_mid_q <= `FIC_WORD_RST;
      operand_input_q <= `FIC_MANT_RST;
      load_sec_q <= `FIC_SEC_LOW;
    end else begin
      start_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      case (m_q)
        M_IDLE: begin
          if (load_cmd.valid) begin
            load_sec_q <= load_cmd.start_addr[7:6]; // RULE20
            case (load_cmd.start_addr[7:6])
              `FIC_SEC_LOW: operand_input_q[0:15] <= load_cmd.word; // RULE19
              `FIC_SEC_MID: operand_input_q[16:31] <= load_cmd.word;
              default: operand_input_q[32:47] <= load_cmd.word;
            endcase
            m_q <= M_LOAD;
          end else if (cmd_valid) begin
            case (cmd_code)
              CMD_INT_TO_FLOAT: begin
                addr_req_q <= 1'b1;
                m_q <= M_I2F_ADDR;
              end
              CMD_FLOAT_TO_INT: m_q <= M_F2I_WAIT;
              CMD_NEGATE: m_q <= M_NEG_WAIT;
              default: cmd_ready_q <= 1'b1;
            endcase
          end else begin
            cmd_ready_q <= 1'b1;
          end
        end
        M_I2F_ADDR: begin
          if (addr_done) begin
            addr_req_q <= 1'b0;
            mem_q <= '{req: 1'b1, write: 1'b0, index: index_reg, wdata: `FIC_WORD_RST}; // RULE1
            m_q <= M_I2F_RD;
          end
        end
        M_I2F_RD: begin
          if (mem_done) begin
            mem_q <= '0;
            prefetch_mid_q <= mem_rdata; // RULE2
            m_q <= M_I2F_WAIT;
          end
        end
        M_I2F_WAIT: begin
          if (!arith_busy_q && !start_q) begin
            operand_input_q[16:31] <= prefetch_mid_q; // RULE3
            operand_input_q[0:15] <= prefetch_mid_q;
            start_q <= 1'b1;
            start_op_q <= OP_I2F;
            m_q <= M_IDLE; // RULE4
          end
        end
        M_F2I_WAIT: begin
          if (!arith_busy_q && !start_q) begin // RULE23
            start_q <= 1'b1; // RULE8
            start_op_q <= OP_F2I;
            addr_req_q <= 1'b1; // RULE9
            m_q <= M_F2I_ADDR;
          end
        end
        M_F2I_ADDR: begin
          if (addr_done) begin
            addr_req_q <= 1'b0;
            m_q <= M_F2I_DONE;
          end
        end
        M_F2I_DONE: begin
          if (f2i_done_q) begin
            mem_q <= '{req: 1'b1, write: 1'b1, index: index_reg, wdata: mant_q[16:31]}; // RULE15
            m_q <= M_F2I_WR;
          end
        end
        M_F2I_WR: begin
          if (mem_done) begin
            mem_q <= '0;
            m_q <= M_IDLE;
          end
        end
        M_NEG_WAIT: begin
          if (!arith_busy_q && !start_q) begin
            start_q <= 1'b1; // RULE16
            start_op_q <= OP_NEG;
            m_q <= M_IDLE;
          end
        end
        M_LOAD: begin
          if (!arith_busy_q && !start_q) begin
            start_q <= 1'b1; // RULE19
            start_op_q <= OP_LOAD;
            m_q <= M_IDLE;
          end
        end
        default: m_q <= M_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Float-to-integer completion flag for the master's store step.
  // A new launch clears it; the arithmetic halt sets it, and the set wins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      f2i_done_q <= 1'b0;
    end else if (arith_busy_q && a_q != A_IDLE && start_op_q == OP_F2I
                 && (a_q == A_F2I_SHIFT || a_q == A_ZERO
                     || (a_q == A_F2I_CMP && exp_q[7] == 1'b0
                         && exp_q > `FIC_EXP_INT_MAX))) begin
      f2i_done_q <= 1'b1;
    end else if (start_q || m_q == M_F2I_WR) begin
      f2i_done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic sequencer.
  // Normalize is bounded by a step counter so a pathological mantissa
  // cannot hold the master waiting forever.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_q <= A_IDLE;
      arith_busy_q <= 1'b0;
      exp_q <= `FIC_EXP_RST;
      mant_q <= `FIC_MANT_RST;
      guard_q <= `FIC_GUARD_RST;
      shift_cnt_q <= `FIC_SC_RST;
      norm_cnt_q <= `FIC_CNT_RST;
    end else begin
      case (a_q)
        A_IDLE: begin
          arith_busy_q <= 1'b0;
          if (start_q) begin
            arith_busy_q <= 1'b1; // RULE23
            case (start_op_q)
              OP_I2F: a_q <= A_I2F_MOVE;
              OP_F2I: a_q <= A_F2I_CMP;
              OP_NEG: a_q <= A_NEG_CMPL;
              default: a_q <= A_LD_COPY;
            endcase
          end
        end
        A_I2F_MOVE: begin
          exp_q <= `FIC_I2F_EXP; // RULE5
          mant_q <= operand_input_q;
          a_q <= A_I2F_FILL;
        end
        A_I2F_FILL: begin
          mant_q[0:15] <= {16{mant_q[0]}}; // RULE6
          mant_q[32:47] <= {16{mant_q[0]}};
          guard_q <= {4{mant_q[0]}};
          norm_cnt_q <= `FIC_CNT_RST;
          a_q <= A_NORM; // RULE7
        end
        A_NORM: begin
          if (mant_q == `FIC_MANT_RST || mant_q == ~`FIC_MANT_RST) begin
            a_q <= A_ZERO;
          end else if (mant_q[0] == mant_q[1] && norm_cnt_q != `FIC_NORM_MAX) begin
            mant_q <= {mant_q[1:47], mant_q[0]};
            exp_q <= exp_q - 8'h01;
            norm_cnt_q <= norm_cnt_q + 6'h01;
          end else begin
            a_q <= A_CLEAN;
          end
        end
        A_F2I_CMP: begin
          if (exp_q[7] == 1'b0 && exp_q > `FIC_EXP_INT_MAX) begin // RULE10
            mant_q[16:31] <= mant_q[0] ? `FIC_NEG_LIMIT : ~`FIC_NEG_LIMIT; // RULE11
            arith_busy_q <= 1'b0;
            a_q <= A_IDLE;
          end else begin
            a_q <= A_F2I_SC;
          end
        end
        A_F2I_SC: begin
          shift_cnt_q <= sc_d; // RULE12
          if ($signed(sc_d) >= $signed(`FIC_SC_ZERO)) begin
            a_q <= A_ZERO; // RULE13
          end else begin
            a_q <= A_F2I_SHIFT;
          end
        end
        A_F2I_SHIFT: begin
          mant_q <= $signed(mant_q) >>> shift_cnt_q[4:0]; // RULE14
          arith_busy_q <= 1'b0;
          a_q <= A_IDLE;
        end
        A_ZERO: begin
          mant_q <= `FIC_MANT_RST; // RULE13
          exp_q <= `FIC_EXP_RST;
          guard_q <= `FIC_GUARD_RST;
          arith_busy_q <= 1'b0;
          a_q <= A_IDLE;
        end
        A_NEG_CMPL: begin
          mant_q <= ~mant_q; // RULE17
          guard_q <= ~guard_q;
          a_q <= A_CLEAN;
        end
        A_CLEAN: begin
          if (exp_q == `FIC_EXP_NEG_ZERO) begin
            exp_q <= `FIC_EXP_RST; // RULE18
          end
          if (mant_q == ~`FIC_MANT_RST) begin
            mant_q <= `FIC_MANT_RST; // RULE22
            guard_q <= `FIC_GUARD_RST;
          end
          arith_busy_q <= 1'b0;
          a_q <= A_IDLE;
        end
        A_LD_COPY: begin
          case (load_sec_q)
            `FIC_SEC_LOW: begin
              mant_q[0:15] <= operand_input_q[0:15]; // RULE21
              guard_q <= {4{operand_input_q[0]}};
            end
            `FIC_SEC_MID: mant_q[16:31] <= operand_input_q[16:31];
            default: mant_q[32:47] <= operand_input_q[32:47];
          endcase
          a_q <= A_LD_EXT;
        end
        A_LD_EXT: begin
          guard_q <= {4{mant_q[0]}}; // RULE22
          a_q <= A_CLEAN;
        end
        default: begin
          arith_busy_q <= 1'b0;
          a_q <= A_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_i2f_read_raw: // RULE1
    assert property (m_q == M_I2F_ADDR && addr_done |=>
                     mem_q.req && !mem_q.write && mem_q.index == $past(index_reg))
    else $error("integer fetch did not use the raw index");
  a_prefetch_load: // RULE2
    assert property (m_q == M_I2F_RD && mem_done |=> prefetch_mid_q == $past(mem_rdata))
    else $error("prefetch middle word not loaded");
  a_i2f_exponent: // RULE5
    assert property (a_q == A_I2F_MOVE |=> exp_q == `FIC_I2F_EXP && mant_q == $past(operand_input_q))
    else $error("integer-to-float start values wrong");
  a_sign_fill: // RULE6
    assert property (a_q == A_I2F_FILL |=> mant_q[0:15] == {16{$past(mant_q[0])}}
                     && mant_q[32:47] == {16{$past(mant_q[0])}})
    else $error("sign fill wrong");
  a_overflow_limit: // RULE11
    assert property (a_q == A_F2I_CMP && !exp_q[7] && exp_q > `FIC_EXP_INT_MAX |=>
                     mant_q[16:31] == ($past(mant_q[0]) ? `FIC_NEG_LIMIT : ~`FIC_NEG_LIMIT)
                     && !arith_busy_q)
    else $error("overflow limit wrong");
  a_force_zero: // RULE13
    assert property (a_q == A_F2I_SC && $signed(sc_d) >= $signed(`FIC_SC_ZERO) |=>
                     ##1 mant_q == `FIC_MANT_RST && exp_q == `FIC_EXP_RST)
    else $error("force zero not applied");
  a_store_word: // RULE15
    assert property (m_q == M_F2I_DONE && f2i_done_q |=>
                     mem_q.req && mem_q.write && mem_q.wdata == $past(mant_q[16:31]))
    else $error("integer store word wrong");
  a_negate_cmpl: // RULE17
    assert property (a_q == A_NEG_CMPL |=> mant_q == ~$past(mant_q) ##1 !arith_busy_q)
    else $error("negation complement wrong");
  a_launch_waits: // RULE23
    assert property (start_q |-> !$past(arith_busy_q))
    else $error("launch while arithmetic busy");

  c_int_to_float: cover property (a_q == A_I2F_FILL ##[1:60] a_q == A_IDLE);
  c_float_overflow: cover property (a_q == A_F2I_CMP ##1 a_q == A_IDLE);
  c_float_store: cover property (m_q == M_F2I_WR && mem_done);
  c_channel_load: cover property (a_q == A_LD_EXT);
endmodule

// file: common/fic_consts.svh
/*
  Constants for the conversion sequencer: exponent figures, shift limits,
  section codes and reset values.
  Assumes inclusion by bare name from the design file.
*/
`ifndef FIC_CONSTS_SVH
`define FIC_CONSTS_SVH
`define FIC_I2F_EXP 8'h17
`define FIC_EXP_INT_MAX 8'h0F
`define FIC_SC_ZERO 9'h017
`define FIC_SC_BASE 9'h017
`define FIC_NEG_LIMIT 16'h8000
`define FIC_SEC_LOW 2'h1
`define FIC_SEC_MID 2'h2
`define FIC_SEC_HIGH 2'h3
`define FIC_EXP_NEG_ZERO 8'hFF
`define FIC_EXP_RST 8'h00
`define FIC_MANT_RST 48'h0000_0000_0000
`define FIC_WORD_RST 16'h0000
`define FIC_GUARD_RST 4'h0
`define FIC_NORM_MAX 6'h2F
`define FIC_CNT_RST 6'h00
`define FIC_SC_RST 9'h000
`endif

// file: common/fic_pkg.sv
/*
  Types shared by the conversion sequencer and its surroundings.
  Assumes the constants header sits beside it.
*/
package fic_pkg;
  typedef enum logic [2:0] {
    CMD_INT_TO_FLOAT,
    CMD_FLOAT_TO_INT,
    CMD_NEGATE,
    CMD_OTHER
  } cmd_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] index;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] start_addr;
    logic [15:0] word;
  } load_cmd_t;
endpackage

// file: sim/host_mem_model.sv
/*
  Host side model: address unit and direct storage channel memory.
  Assumes requests are registered on ref_clk and held until their done pulse.
*/
`timescale 1ns/1ns
module host_mem_model (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [3:0] lat, // Extra cycles before each answer
  input wire logic [15:0] rd_word, // Word that memory returns on a read
  input wire logic addr_req_q, // Address fetch request
  output logic addr_done, // Address fetch finished pulse
  input wire fic_pkg::mem_req_t mem_q, // Memory cycle request
  output logic mem_done, // Memory cycle finished pulse
  output logic [15:0] mem_rdata // Read data, valid only with mem_done
);
  import fic_pkg::*;
  logic [3:0] a_cnt_q;
  logic [3:0] m_cnt_q;
  int n_addr;
  int n_rd;
  int n_wr;
  logic [15:0] rd_index;
  logic [15:0] wr_index;
  logic [15:0] wr_data;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      a_cnt_q <= 4'h0;
      addr_done <= 1'b0;
      n_addr <= 0;
    end else begin
      addr_done <= 1'b0;
      a_cnt_q <= 4'h0;
      if (addr_req_q && !addr_done) begin
        if (a_cnt_q != lat) begin
          a_cnt_q <= a_cnt_q + 4'h1;
        end else begin
          addr_done <= 1'b1;
          n_addr <= n_addr + 1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read data toggles outside the done cycle so a late sample is never lucky.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      m_cnt_q <= 4'h0;
      mem_done <= 1'b0;
      mem_rdata <= 16'h0000;
      n_rd <= 0;
      n_wr <= 0;
    end else begin
      mem_done <= 1'b0;
      m_cnt_q <= 4'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_q.req && !mem_done) begin
        if (m_cnt_q != lat) begin
          m_cnt_q <= m_cnt_q + 4'h1;
        end else if (mem_q.write) begin
          mem_done <= 1'b1;
          wr_index <= mem_q.index;
          wr_data <= mem_q.wdata;
          n_wr <= n_wr + 1;
        end else begin
          mem_done <= 1'b1;
          mem_rdata <= rd_word;
          rd_index <= mem_q.index;
          n_rd <= n_rd + 1;
        end
      end
    end
  end
endmodule

// file: sim/testbench.sv
/*
  Self-checking bench for the conversion sequencer.
  Assumes the host model answers every request; one clock domain.
*/
`timescale 1ns/1ns
module testbench;
  import fic_pkg::*;
  logic ref_clk;
  logic rst;
  logic cmd_valid;
  cmd_t cmd_code;
  logic cmd_ready_q;
  logic [15:0] index_reg;
  load_cmd_t load_cmd;
  logic addr_req_q;
  logic addr_done;
  mem_req_t mem_q;
  logic mem_done;
  logic [15:0] mem_rdata;
  logic arith_busy_q;
  logic [7:0] exp_q;
  logic [0:47] mant_q;
  logic [3:0] guard_q;
  logic [3:0] lat;
  logic [15:0] rd_word;
  int n_errors;
  int checked;
  int cycles;
  ////////////////////////////////////////////////////////////////////////////
  float_int_convert_sequencer i_dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready_q(cmd_ready_q), .index_reg(index_reg), .load_cmd(load_cmd),
    .addr_req_q(addr_req_q), .addr_done(addr_done), .mem_q(mem_q), .mem_done(mem_done),
    .mem_rdata(mem_rdata), .arith_busy_q(arith_busy_q), .exp_q(exp_q), .mant_q(mant_q), .guard_q(guard_q));
  host_mem_model i_mem (.ref_clk(ref_clk), .rst(rst), .lat(lat), .rd_word(rd_word),
    .addr_req_q(addr_req_q), .addr_done(addr_done), .mem_q(mem_q), .mem_done(mem_done),
    .mem_rdata(mem_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic issue(input cmd_t c);
    int i;
    for (i = 0; i < 300 && cmd_ready_q !== 1'b1; i++) tick();
    cmd_code = c;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    tick();
    tick();
  endtask
  // Settles only once both sequencers are quiet and no memory cycle is open.
  task automatic settle();
    int i;
    for (i = 0; i < 100 && arith_busy_q !== 1'b1; i++) tick();
    for (i = 0; i < 300 && !(cmd_ready_q === 1'b1 && arith_busy_q === 1'b0 && mem_q.req === 1'b0); i++) tick();
    chk("idle reached", 48'h1, {47'h0, (i < 300)});
  endtask
  task automatic load(input logic [1:0] sec, input logic [15:0] w);
    int i;
    for (i = 0; i < 300 && cmd_ready_q !== 1'b1; i++) tick();
    load_cmd = '{valid: 1'b1, start_addr: {sec, 6'h00}, word: w};
    tick();
    load_cmd.valid = 1'b0;
    settle();
  endtask
  // Sign fill, exponent 17 hex, then rotate left while the top two bits agree.
  function automatic logic [55:0] i2f_ref(input logic [15:0] v);
    logic [0:47] m;
    logic [7:0] e;
    int k;
    m = {{16{v[15]}}, v, {16{v[15]}}};
    e = 8'h17;
    for (k = 0; k < 47 && m[0] == m[1]; k++) begin
      m = {m[1:47], m[0]};
      e = e - 8'h01;
    end
    return {e, m};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_i2f(input logic [15:0] v);
    int n0;
    int i;
    logic [55:0] r;
    r = i2f_ref(v);
    n0 = i_mem.n_rd;
    rd_word = v;
    index_reg = 16'h0005;
    issue(CMD_INT_TO_FLOAT);
    for (i = 0; i < 100 && arith_busy_q !== 1'b1; i++) tick();
    for (i = 0; i < 10 && cmd_ready_q !== 1'b1; i++) tick();
    chk("ready while converting", 48'h1, {47'h0, cmd_ready_q & arith_busy_q});
    settle();
    chk("read count", 48'h1, 48'(i_mem.n_rd - n0));
    chk("read index", 48'h5, {32'h0, i_mem.rd_index});
    chk("i2f exponent", {40'h0, r[55:48]}, {40'h0, exp_q});
    chk("i2f mantissa", r[47:0], mant_q);
    $display("test int_to_float %h done", v);
  endtask
  // Float-to-int is queued behind a running conversion, so it must wait.
  task automatic t_f2i(input logic [15:0] v, input logic [15:0] res);
    int nw;
    int na;
    nw = i_mem.n_wr;
    na = i_mem.n_addr;
    rd_word = v;
    index_reg = 16'h0009;
    issue(CMD_INT_TO_FLOAT);
    issue(CMD_FLOAT_TO_INT);
    settle();
    chk("write count", 48'h1, 48'(i_mem.n_wr - nw));
    chk("write index", 48'h9, {32'h0, i_mem.wr_index});
    chk("write data", {32'h0, res}, {32'h0, i_mem.wr_data});
    chk("address fetches", 48'h2, 48'(i_mem.n_addr - na));
    if (res == 16'h0000) begin
      chk("forced zero", 48'h0, mant_q);
    end
    $display("test float_to_int %h done", v);
  endtask
  task automatic t_load();
    load(2'h1, 16'h8001);
    chk("low load", {16'h8001, 32'h0}, {mant_q[0:15], 32'h0});
    chk("guard fill", 48'hF, {44'h0, guard_q});
    load(2'h2, 16'h3456);
    load(2'h3, 16'h789A);
    load(2'h1, 16'h0012);
    chk("three sections", 48'h0012_3456_789A, mant_q);
    chk("guard clear", 48'h0, {44'h0, guard_q});
    $display("test load done");
  endtask
  task automatic t_neg();
    logic [7:0] e;
    e = exp_q;
    issue(CMD_NEGATE);
    settle();
    chk("negated", 48'hFFED_CBA9_8765, mant_q);
    chk("exponent kept", {40'h0, e}, {40'h0, exp_q});
    load(2'h1, 16'hFFFF);
    load(2'h2, 16'hFFFF);
    load(2'h3, 16'hFFFF);
    chk("negative zero load", 48'h0, mant_q);
    load(2'h1, 16'h0000);
    load(2'h2, 16'h0000);
    load(2'h3, 16'h0000);
    issue(CMD_NEGATE);
    settle();
    chk("negative zero negate", 48'h0, mant_q);
    $display("test negate done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = CMD_OTHER;
    index_reg = 16'h0000;
    load_cmd = '0;
    lat = 4'h0;
    rd_word = 16'h0000;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_i2f(16'h4000);
    t_i2f(16'hBFFF);
    lat = 4'h3;
    t_f2i(16'h4000, 16'h4000);
    t_f2i(16'hBFFF, 16'hBFFF);
    t_f2i(16'h0100, 16'h0100);
    t_f2i(16'h0080, 16'h0000);
    t_f2i(16'hFFFE, 16'h0000);
    lat = 4'h0;
    t_load();
    t_neg();
    stop_test();
  end
endmodule
